//--- hdl/dre_defs.vh
// Constants for the double-rate pin register block.
// Assumes inclusion by bare name from the block's own design file.
`ifndef DRE_DEFS_VH
`define DRE_DEFS_VH

// ----------------------------------------
// Register map, byte addresses
// ----------------------------------------
`define DRE_ADDR_W 8
`define DRE_CFG_BASE 8'h00
`define DRE_STAT_BASE 8'h10
`define DRE_CFG_RESET 32'h00000000

// ----------------------------------------
// Configuration word fields
// ----------------------------------------
`define DRE_F_MODE_LO 0
`define DRE_F_MODE_HI 1
`define DRE_F_PWRUP 2
`define DRE_F_USE_ACLR 3
`define DRE_F_USE_SCLR 4
`define DRE_F_INV_A 5
`define DRE_F_INV_B 6
`define DRE_F_INV_OE 7
`define DRE_F_INV_CEIN 8
`define DRE_F_INV_CEOUT 9
`define DRE_F_INV_ACLR 10
`define DRE_F_INV_SCLR 11
`define DRE_F_OE_SEL_LO 12
`define DRE_F_OE_SEL_HI 13
`define DRE_F_CEIN_SEL_LO 14
`define DRE_F_CEIN_SEL_HI 15
`define DRE_F_CEOUT_SEL_LO 16
`define DRE_F_CEOUT_SEL_HI 17
`define DRE_F_ACLR_SEL_LO 18
`define DRE_F_ACLR_SEL_HI 19
`define DRE_F_SCLR_SEL_LO 20
`define DRE_F_SCLR_SEL_HI 21
`define DRE_F_CLKIN_SEL_LO 22
`define DRE_F_CLKIN_SEL_HI 24
`define DRE_F_CLKOUT_SEL_LO 25
`define DRE_F_CLKOUT_SEL_HI 27

// ----------------------------------------
// Modes
// ----------------------------------------
`define DRE_MODE_SDR 2'h0
`define DRE_MODE_DDR_IN 2'h1
`define DRE_MODE_DDR_OUT 2'h2
`define DRE_MODE_DDR_BIDIR 2'h3

// ----------------------------------------
// Status word fields
// ----------------------------------------
`define DRE_S_CAP_RISE 0
`define DRE_S_CAP_LATE 1
`define DRE_S_LAUNCH_A 2
`define DRE_S_LAUNCH_B 3
`define DRE_S_OE_N 4
`define DRE_S_PIN 5

`endif

//--- hdl/dre_io_block.v
// One I/O block of four double-rate pin register cells, with a config port.
// Assumes core-side inputs and block clock lines are synchronous to sys_clk;
// the pad drives pin_in, and the pad buffer resolves pin_out and pin_oe_n.
//
// The plain strobed port and the register offsets were left to the implementer.
`timescale 1ns/1ns
`include "dre_defs.vh"

module dre_io_block #(
	parameter NUM_CELLS = 4,
	parameter NUM_CLK_LINES = 8
)
(
	input wire sys_clk,
	input wire reset_n,
	input wire [`DRE_ADDR_W-1:0] reg_addr,
	input wire [31:0] reg_wdata,
	input wire reg_wr,
	input wire reg_rd,
	output reg [31:0] reg_rdata,
	input wire [NUM_CLK_LINES-1:0] blk_clk_line,
	input wire [NUM_CELLS-1:0] core_dout_a,
	input wire [NUM_CELLS-1:0] core_dout_b,
	input wire [NUM_CELLS-1:0] core_oe,
	input wire [NUM_CELLS-1:0] core_ce_in,
	input wire [NUM_CELLS-1:0] core_ce_out,
	input wire [NUM_CELLS-1:0] core_aclr,
	input wire [NUM_CELLS-1:0] core_sclr,
	output wire [NUM_CELLS-1:0] core_din_a,
	output wire [NUM_CELLS-1:0] core_din_b,
	input wire [NUM_CELLS-1:0] pin_in,
	output wire [NUM_CELLS-1:0] pin_out,
	output wire [NUM_CELLS-1:0] pin_oe_n
);

	// ----------------------------------------
	// Configuration registers
	// ----------------------------------------
	reg [31:0] cfg_reg [0:NUM_CELLS-1];
	wire [31:0] stat_w [0:NUM_CELLS-1];
	wire cfg_hit;
	wire stat_hit;
	integer k;

	assign cfg_hit = ({reg_addr[7:4], 4'h0} == `DRE_CFG_BASE);
	assign stat_hit = ({reg_addr[7:4], 4'h0} == `DRE_STAT_BASE);

	always @(posedge sys_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			for (k = 0; k < NUM_CELLS; k = k + 1)
				cfg_reg[k] <= `DRE_CFG_RESET;
		end
		else if (reg_wr && cfg_hit)
		begin
			cfg_reg[reg_addr[3:2]] <= reg_wdata;
		end
	end

	// Unmapped addresses read as zero
	always @(posedge sys_clk or negedge reset_n)
	begin
		if (!reset_n)
			reg_rdata <= 32'h00000000;
		else if (reg_rd && cfg_hit)
			reg_rdata <= cfg_reg[reg_addr[3:2]];
		else if (reg_rd && stat_hit)
			reg_rdata <= stat_w[reg_addr[3:2]];
		else
			reg_rdata <= 32'h00000000;
	end

	// ----------------------------------------
	// Pin register cells
	// ----------------------------------------
	genvar i;
	generate
		for (i = 0; i < NUM_CELLS; i = i + 1)
		begin : g_cell
			wire [31:0] c;
			wire [1:0] mode;
			wire lvl;
			wire a_d;
			wire b_d;
			wire oe_d;
			wire ce_in_d;
			wire ce_out_d;
			wire aclr_d;
			wire sclr_d;
			wire cap_en;
			wire lch_en;
			wire arst_n;
			wire sclr_hit;
			wire la;
			wire lb;
			wire oer;
			wire oef;
			// Stored value XOR power-up level, except the two pin sync stages, so reset needs only a constant
			reg cap_rise_reg;
			reg cap_fall_reg;
			reg cap_late_reg;
			reg lch_a_reg;
			reg lch_b_reg;
			reg oe_rise_reg;
			reg oe_fall_reg;
			reg pin_meta_reg;
			reg pin_sync_reg;

			assign c = cfg_reg[i];
			assign mode = c[`DRE_F_MODE_HI:`DRE_F_MODE_LO];
			assign lvl = c[`DRE_F_PWRUP];

			// Control signals selected from the shared bundle, data taken from the cell's own bit, then inversion
			assign a_d = core_dout_a[i] ^ c[`DRE_F_INV_A];
			assign b_d = core_dout_b[i] ^ c[`DRE_F_INV_B];
			assign oe_d = core_oe[c[`DRE_F_OE_SEL_HI:`DRE_F_OE_SEL_LO]] ^ c[`DRE_F_INV_OE];
			assign ce_in_d = core_ce_in[c[`DRE_F_CEIN_SEL_HI:`DRE_F_CEIN_SEL_LO]]
				^ c[`DRE_F_INV_CEIN];
			assign ce_out_d = core_ce_out[c[`DRE_F_CEOUT_SEL_HI:`DRE_F_CEOUT_SEL_LO]]
				^ c[`DRE_F_INV_CEOUT];
			assign aclr_d = core_aclr[c[`DRE_F_ACLR_SEL_HI:`DRE_F_ACLR_SEL_LO]]
				^ c[`DRE_F_INV_ACLR];
			assign sclr_d = core_sclr[c[`DRE_F_SCLR_SEL_HI:`DRE_F_SCLR_SEL_LO]]
				^ c[`DRE_F_INV_SCLR];

			// Capture side has its own line and enable
			assign cap_en = blk_clk_line[c[`DRE_F_CLKIN_SEL_HI:`DRE_F_CLKIN_SEL_LO]] & ce_in_d;
			// Launch and drive enable always share one
			assign lch_en = blk_clk_line[c[`DRE_F_CLKOUT_SEL_HI:`DRE_F_CLKOUT_SEL_LO]] & ce_out_d;

			// Gated reset: core must keep aclr glitch free
			assign arst_n = reset_n & ~(c[`DRE_F_USE_ACLR] & aclr_d);
			assign sclr_hit = c[`DRE_F_USE_SCLR] & sclr_d;

			// ----------------------------------------
			// Rising-edge registers
			// ----------------------------------------
			always @(posedge sys_clk or negedge arst_n)
			begin
				if (!arst_n)
				begin
					cap_rise_reg <= 1'b0;
					cap_late_reg <= 1'b0;
					lch_a_reg <= 1'b0;
					lch_b_reg <= 1'b0;
					oe_rise_reg <= 1'b0;
				end
				else if (sclr_hit)
				begin
					cap_rise_reg <= 1'b0;
					cap_late_reg <= 1'b0;
					lch_a_reg <= 1'b0;
					lch_b_reg <= 1'b0;
					oe_rise_reg <= 1'b0;
				end
				else
				begin
					if (cap_en)
					begin
						cap_rise_reg <= pin_in[i] ^ lvl;
						// Flop stands in for the latch, retimes high-phase bit
						cap_late_reg <= cap_fall_reg;
					end
					if (lch_en)
					begin
						lch_a_reg <= a_d ^ lvl;
						lch_b_reg <= b_d ^ lvl;
						// Stored inverted: low means drive
						oe_rise_reg <= ~oe_d ^ lvl;
					end
				end
			end

			// ----------------------------------------
			// Falling-edge registers
			// ----------------------------------------
			always @(negedge sys_clk or negedge arst_n)
			begin
				if (!arst_n)
				begin
					cap_fall_reg <= 1'b0;
					oe_fall_reg <= 1'b0;
				end
				else if (sclr_hit)
				begin
					cap_fall_reg <= 1'b0;
					oe_fall_reg <= 1'b0;
				end
				else
				begin
					if (cap_en)
						cap_fall_reg <= pin_in[i] ^ lvl;
					if (lch_en)
						oe_fall_reg <= oe_rise_reg;
				end
			end

			// Status view of the pin only; two stages since the pad is async
			always @(posedge sys_clk or negedge reset_n)
			begin
				if (!reset_n)
				begin
					pin_meta_reg <= 1'b0;
					pin_sync_reg <= 1'b0;
				end
				else
				begin
					pin_meta_reg <= pin_in[i];
					pin_sync_reg <= pin_meta_reg;
				end
			end

			// ----------------------------------------
			// Pin and core outputs
			// ----------------------------------------
			assign la = lch_a_reg ^ lvl;
			assign lb = lch_b_reg ^ lvl;
			assign oer = oe_rise_reg ^ lvl;
			assign oef = oe_fall_reg ^ lvl;

			// Clock-level mux: the only way to toggle at twice the clock rate
			assign pin_out[i] = (mode == `DRE_MODE_DDR_OUT || mode == `DRE_MODE_DDR_BIDIR)
				? (sys_clk ? la : lb) : la;
			assign pin_oe_n[i] = (mode == `DRE_MODE_DDR_IN) ? 1'b1
				: (mode == `DRE_MODE_DDR_BIDIR) ? (oer | oef) : oer;

			assign core_din_a[i] = cap_rise_reg ^ lvl;
			assign core_din_b[i] = cap_late_reg ^ lvl;

			assign stat_w[i] = {26'h0000000, pin_sync_reg, pin_oe_n[i], lb, la,
				core_din_b[i], core_din_a[i]};
		end
	endgenerate

endmodule // dre_io_block

//--- testbench/dre_io_block_monitor.sv
// Checker on cell 0 of the pin register block.
// Assumes a bind to the block; sees its ports only.
`timescale 1ns/1ns
module dre_io_block_monitor #(parameter NUM_CELLS = 4, parameter NUM_CLK_LINES = 8)
(
	input wire sys_clk,
	input wire reset_n,
	input wire [7:0] reg_addr,
	input wire [31:0] reg_wdata,
	input wire reg_wr,
	input wire reg_rd,
	input wire [31:0] reg_rdata,
	input wire [NUM_CLK_LINES-1:0] blk_clk_line,
	input wire [NUM_CELLS-1:0] core_dout_a,
	input wire [NUM_CELLS-1:0] core_oe,
	input wire [NUM_CELLS-1:0] core_ce_out,
	input wire [NUM_CELLS-1:0] core_aclr,
	input wire [NUM_CELLS-1:0] core_sclr,
	input wire [NUM_CELLS-1:0] core_din_a,
	input wire [NUM_CELLS-1:0] pin_out,
	input wire [NUM_CELLS-1:0] pin_oe_n
);
	reg [31:0] c_reg;
	// Own copy of cell 0 config, since it is not visible at the ports
	always @(posedge sys_clk or negedge reset_n)
		if (!reset_n)
			c_reg <= 32'h0;
		else if (reg_wr && reg_addr[7:2] == 6'h00)
			c_reg <= reg_wdata;
	wire [1:0] md = c_reg[1:0];
	wire ld = blk_clk_line[c_reg[27:25]] & (core_ce_out[c_reg[17:16]] ^ c_reg[9]);
	wire sc = c_reg[4] & (core_sclr[c_reg[21:20]] ^ c_reg[11]);
	wire ac = c_reg[3] & (core_aclr[c_reg[19:18]] ^ c_reg[10]);
	wire oq = core_oe[c_reg[13:12]] ^ c_reg[7];
	wire pl = !sc && !ac && !c_reg[2] && !reg_wr;
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!reset_n);
	rd_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0) else $error("stray read data");
	sdr_launch_a: assert property (md == 2'h0 && ld && pl |=> pin_out[0] == $past(core_dout_a[0] ^ c_reg[5]))
		else $error("launch data wrong");
	sdr_oe_a: assert property (md == 2'h0 && ld && pl |=> pin_oe_n[0] == !$past(oq))
		else $error("drive enable wrong");
	ddrin_hiz_a: assert property (md == 2'h1 |-> pin_oe_n[0]) else $error("driver on in input mode");
	aclr_now_a: assert property (ac |-> core_din_a[0] == c_reg[2]) else $error("async clear late");
	sclr_hold_a: assert property (sc && !ac && !reg_wr |=> core_din_a[0] == c_reg[2])
		else $error("sync clear missed");
	bidir_oe_a: assert property (md == 2'h3 && ld && oq && pin_oe_n[0] && pl |=> !pin_oe_n[0])
		else $error("bidir enable stuck");
	aclr_pin_a: assert property (ac && !c_reg[1] |-> pin_out[0] == c_reg[2]) else $error("pin not cleared");
	cover property (md == 2'h2 && ld);
	cover property (ac);
	cover property (sc);
	cover property (md == 2'h3 && ld && oq && pin_oe_n[0]);
endmodule // dre_io_block_monitor
bind dre_io_block dre_io_block_monitor #(.NUM_CELLS(NUM_CELLS), .NUM_CLK_LINES(NUM_CLK_LINES)) i_mon (.*);

//--- testbench/dre_pin_model.sv
// Pad-side model: the far device watches the pin and drives it when released.
// Assumes no pull resistor, so a released pin carries the bench pattern.
`timescale 1ns/1ns
module dre_pin_model #(parameter NUM_CELLS = 4)
(
	input wire [NUM_CELLS-1:0] pin_out,
	input wire [NUM_CELLS-1:0] pin_oe_n,
	input wire [NUM_CELLS-1:0] ext_drive,
	output wire [NUM_CELLS-1:0] pin_in
);
	// Block wins the wire only while its enable is low
	assign pin_in = (pin_out & ~pin_oe_n) | (ext_drive & pin_oe_n);
endmodule // dre_pin_model

//--- testbench/tb_top.sv
// Bench: register port tasks and pin scenarios on cell 0.
// Assumes the pad model echoes driven pins into pin_in.
`timescale 1ns/1ns
module tb_top;
	reg sys_clk, reset_n, reg_wr, reg_rd, p;
	reg [7:0] reg_addr, blk_clk_line;
	reg [31:0] reg_wdata;
	reg [3:0] core_dout_a, core_dout_b, core_oe, core_ce_in, core_ce_out, core_aclr, core_sclr, ext_drive;
	wire [31:0] reg_rdata;
	wire [3:0] core_din_a, core_din_b, pin_in, pin_out, pin_oe_n;
	integer num_errors = 0, cmp_count = 0, cyc = 0, i;
	dre_io_block i_dre_io_block (.*);
	dre_pin_model i_dre_pin_model (.*);
	initial
	begin
		sys_clk = 1'h0;
		forever #10 sys_clk = ~sys_clk;
	end
	always @(posedge sys_clk)
	begin
		cyc = cyc + 1;
		if (cyc == 2000)
		begin
			num_errors = num_errors + 1;
			print_verdict;
		end
	end
	task print_verdict;
	begin
		if (num_errors == 0 && cmp_count > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	end
	endtask
	task chk(input [31:0] seen, input [31:0] exp);
	begin
		cmp_count = cmp_count + 1;
		if (seen !== exp)
		begin
			num_errors = num_errors + 1;
			$display("wrong value at %0t: %h expected %h", $time, seen, exp);
		end
	end
	endtask
	task wr(input [7:0] a, input [31:0] d);
	begin
		@(posedge sys_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'h1;
		@(posedge sys_clk);
		reg_wr <= 1'h0;
	end
	endtask
	task rd(input [7:0] a, input [31:0] exp);
	begin
		@(posedge sys_clk);
		reg_addr <= a;
		reg_rd <= 1'h1;
		@(posedge sys_clk);
		reg_rd <= 1'h0;
		#1 chk(reg_rdata, exp);
	end
	endtask
	initial
	begin
		{reg_addr, reg_wdata, reg_wr, reg_rd, blk_clk_line, core_dout_a, core_dout_b} = 0;
		{core_oe, core_ce_in, core_ce_out, core_aclr, core_sclr, ext_drive, reset_n} = 0;
		repeat (20) @(posedge sys_clk);
		reset_n <= 1'h1;
		for (i = 0; i < 4; i = i + 1)
			rd(i[5:0] << 2, 32'h0);
		rd(8'h20, 32'h0);
		wr(8'h04, 32'h0FFFFFFF);
		rd(8'h04, 32'h0FFFFFFF);
		wr(8'h00, 32'h06020000);
		blk_clk_line <= 8'h08;
		core_ce_out <= 4'h4;
		core_dout_a <= 4'h1;
		core_oe <= 4'h1;
		@(posedge sys_clk);
		blk_clk_line <= 8'hF7;
		core_dout_a <= 4'h0;
		#1 chk({pin_oe_n[0], pin_out[0]}, 2'h1);
		@(posedge sys_clk);
		#1 chk(pin_out[0], 1'h1);
		wr(8'h00, 32'h06020020);
		blk_clk_line <= 8'hFF;
		core_dout_a <= 4'h1;
		@(posedge sys_clk);
		#1 chk(pin_out[0], 1'h0);
		wr(8'h00, 32'h00000002);
		core_ce_out <= 4'h5;
		for (i = 0; i < 4; i = i + 1)
		begin
			@(posedge sys_clk);
			core_dout_a <= {3'h0, i[0]};
			core_dout_b <= {3'h0, i[1]};
			@(posedge sys_clk);
			#2 chk(pin_out[0], i[0]);
			@(negedge sys_clk);
			#2 chk(pin_out[0], i[1]);
		end
		wr(8'h00, 32'h00000001);
		core_ce_in <= 4'h1;
		for (i = 0; i < 5; i = i + 1)
		begin
			@(negedge sys_clk) ext_drive <= {3'h0, i[0]};
			@(posedge sys_clk) ext_drive <= {3'h0, ~i[1]};
			#1 chk(pin_oe_n[0], 1'h1);
			if (i > 0)
				chk({core_din_b[0], core_din_a[0]}, {p, i[0]});
			p = ~i[1];
		end
		wr(8'h00, 32'h0000000C);
		core_aclr <= 4'h1;
		#1 chk({core_din_a[0], pin_out[0]}, 2'h3);
		@(posedge sys_clk);
		core_aclr <= 4'h0;
		wr(8'h00, 32'h00000010);
		repeat (3) @(posedge sys_clk);
		core_sclr <= 4'h1;
		#1 chk(core_din_a[0], 1'h1);
		@(posedge sys_clk);
		core_sclr <= 4'h0;
		#1 chk(core_din_a[0], 1'h0);
		wr(8'h00, 32'h00000003);
		core_oe <= 4'h0;
		@(posedge sys_clk);
		core_oe <= 4'h1;
		@(posedge sys_clk);
		#1 chk(pin_oe_n[0], 1'h1);
		@(negedge sys_clk);
		#1 chk(pin_oe_n[0], 1'h0);
		@(posedge sys_clk);
		#1 chk(pin_oe_n[0], 1'h0);
		rd(8'h14, 32'h0000001F);
		print_verdict;
	end
endmodule // tb_top
